// file: qpc_quadrature_position_counter.sv
`timescale 1ns/1ps
// Functional notes
// - Count up when B rising lags A rising, down for opposite rotation.
// - Step on every rising and falling edge of A or B, unless both change in one cycle: four per line pair.
// - At maximum, a further positive edge wraps count to zero.
// - At zero, a negative edge loads the maximum value.
// - In index-reset modes, rising index edge clears the count.
// - Free mode: wrap only, index ignored, index outputs held low.
// - Capture mode: wrap only, count latched at each index pulse.
// - Reset-by-index mode: clear on every index, no latched output.
// - Reset-by-first-index: clear only on first index after start-up.
// - Polarity setting inverts A and B only; index pulse always starts on its rising edge.
// - Index taken from decoder input two or direct, per routing option.
module qpc_quadrature_position_counter
  import qpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // encoder pins
  input wire qpc_enc_t enc,
  // configuration
  input wire qpc_cfg_t cfg,
  // results
  output logic [CNT_W-1:0] count,
  output logic indexPulse,
  output logic [CNT_W-1:0] index_latched_count_out,
  output logic latchedValid,
  output logic firstIndexSeen
);

  function automatic logic [CNT_W-1:0] stepCount(input logic [CNT_W-1:0] c,
                                                  input logic up,
                                                  input logic [CNT_W-1:0] mx);
    if (up) begin
      stepCount = (c >= mx) ? '0 : c + 1'b1;
    end else begin
      stepCount = (c == '0) ? mx : c - 1'b1;
    end
  endfunction : stepCount

  // two-stage synchronisers; stage one read only by stage two
  logic [3:0] syncA_r;
  logic [3:0] syncB_r;
  logic [3:1] seen_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {enc.chanA, enc.chanB, enc.idxDecoder, enc.idxDirect};
      syncB_r <= syncA_r;
    end
  end

  // polarity only flips the channels; quadrature order survives inversion
  logic aNow;
  logic bNow;
  logic iNow;
  assign aNow = syncB_r[3] ^ cfg.invertPolarity;
  assign bNow = syncB_r[2] ^ cfg.invertPolarity;
  assign iNow = (cfg.idxRoute == IDX_ROUTE_DIRECT) ? syncB_r[0] : syncB_r[1];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seen_r <= '0;
    end else begin
      seen_r <= {aNow, bNow, iNow};
    end
  end

  logic aChg;
  logic bChg;
  logic stepValid;
  logic stepUp;
  logic idxRise;
  assign aChg = aNow ^ seen_r[3];
  assign bChg = bNow ^ seen_r[2];
  assign stepValid = aChg ^ bChg;
  // A leading B: after an A change A != B, after a B change A == B
  assign stepUp = aChg ? (aNow != bNow) : (aNow == bNow);
  assign idxRise = iNow & ~seen_r[1] & (cfg.mode != QPC_FREE);

  logic idxClear;
  assign idxClear = idxRise & ((cfg.mode == QPC_RST_EVERY) ||
                    ((cfg.mode == QPC_RST_FIRST) && !firstIndexSeen));

  logic [CNT_W-1:0] count_nxt;
  always_comb begin
    count_nxt = count;
    if (idxClear) begin
      count_nxt = '0;
    end else if (stepValid) begin
      count_nxt = stepCount(count, stepUp, cfg.maxCount);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
    end else begin
      count <= count_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      firstIndexSeen <= 1'b0;
    end else if (idxRise && cfg.mode == QPC_RST_FIRST) begin
      firstIndexSeen <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      indexPulse <= 1'b0;
    end else begin
      indexPulse <= idxRise;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      index_latched_count_out <= '0;
      latchedValid <= 1'b0;
    end else if (cfg.mode != QPC_FREE_CAPT) begin
      index_latched_count_out <= '0;
      latchedValid <= 1'b0;
    end else if (idxRise) begin
      index_latched_count_out <= count;
      latchedValid <= 1'b1;
    end
  end

  a_up_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (stepValid && stepUp && !idxClear && count == cfg.maxCount) |=> count == '0)
    else $error("up step at maximum did not wrap to zero");

  a_down_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (stepValid && !stepUp && !idxClear && count == '0) |=> count == $past(cfg.maxCount))
    else $error("down step at zero did not load maximum");

  a_idx_clear: assert property (@(posedge clk) disable iff (!reset_n)
    idxClear |=> count == '0)
    else $error("index reset did not clear count");

  a_free_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode == QPC_FREE) [*2] |-> !indexPulse && index_latched_count_out == '0)
    else $error("free mode drove index outputs");

  a_capt_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (idxRise && cfg.mode == QPC_FREE_CAPT) |=> index_latched_count_out == $past(count))
    else $error("index capture missed count");

  a_rst_nolatch: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode == QPC_RST_EVERY) [*2] |-> index_latched_count_out == '0 && !latchedValid)
    else $error("latched output active in reset-by-index mode");

  a_first_only: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode == QPC_RST_FIRST && firstIndexSeen && idxRise && !stepValid) |=> $stable(count))
    else $error("later index cleared count in first-index mode");

  a_bad_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (aChg && bChg && !idxClear) |=> $stable(count))
    else $error("double channel change moved count");

  a_up_step: assert property (@(posedge clk) disable iff (!reset_n)
    (stepValid && stepUp && !idxClear && count < cfg.maxCount) |=> count == $past(count) + 1'b1)
    else $error("forward step did not increment");

  a_down_step: assert property (@(posedge clk) disable iff (!reset_n)
    (stepValid && !stepUp && !idxClear && count != '0) |=> count == $past(count) - 1'b1)
    else $error("reverse step did not decrement");

  // outputs are registered, so every check below looks one edge after the decision
  a_idle_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (!stepValid && !idxClear) |=> $stable(count))
    else $error("count moved without an edge");

  a_idx_single: assert property (@(posedge clk) disable iff (!reset_n)
    indexPulse |=> !indexPulse)
    else $error("index pulse wider than one cycle");

  a_free_noclr: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode inside {QPC_FREE, QPC_FREE_CAPT} && !stepValid) |=> $stable(count))
    else $error("free-running count cleared by index");

  a_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode == QPC_FREE_CAPT && !idxRise) |=> $stable(index_latched_count_out))
    else $error("latched count changed without index");

  a_capt_valid: assert property (@(posedge clk) disable iff (!reset_n)
    (idxRise && cfg.mode == QPC_FREE_CAPT) |=> latchedValid)
    else $error("capture did not flag latched count");

  a_rst_every: assert property (@(posedge clk) disable iff (!reset_n)
    (idxRise && cfg.mode == QPC_RST_EVERY) |=> count == '0)
    else $error("index did not clear count in reset-by-index mode");

  a_latch_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode != QPC_FREE_CAPT) |=> (index_latched_count_out == '0 && !latchedValid))
    else $error("latched output active outside capture mode");

  a_first_set: assert property (@(posedge clk) disable iff (!reset_n)
    (idxRise && cfg.mode == QPC_RST_FIRST) |=> firstIndexSeen)
    else $error("first index not recorded");

  a_first_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    firstIndexSeen |=> firstIndexSeen)
    else $error("first index record lost");

  // a polarity flip moves both channels at once, so it must never count by itself
  a_pol_flip: assert property (@(posedge clk) disable iff (!reset_n)
    ($changed(cfg.invertPolarity) && $stable(syncB_r[3:2]) && !idxClear) |=> $stable(count))
    else $error("polarity change stepped the count");

  a_route_direct: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode != QPC_FREE && cfg.idxRoute == IDX_ROUTE_DIRECT && $stable(cfg.idxRoute) &&
     $rose(syncB_r[0])) |=> indexPulse)
    else $error("direct index input not seen");

endmodule : qpc_quadrature_position_counter

// file: qpc_pkg.sv
package qpc_pkg;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] MAX_RESET = 16'h0FFF;

  // index handling modes
  typedef enum logic [1:0] {
    QPC_FREE      = 2'b00,
    QPC_FREE_CAPT = 2'b01,
    QPC_RST_FIRST = 2'b11,
    QPC_RST_EVERY = 2'b10
  } qpc_mode_t;

  // index source select
  localparam logic IDX_ROUTE_DECODER = 1'b0;
  localparam logic IDX_ROUTE_DIRECT = 1'b1;

  // encoder pins together
  typedef struct packed {
    logic chanA;
    logic chanB;
    logic idxDecoder;
    logic idxDirect;
  } qpc_enc_t;

  typedef struct packed {
    qpc_mode_t mode;
    logic invertPolarity;
    logic idxRoute;
    logic [CNT_W-1:0] maxCount;
  } qpc_cfg_t;

endpackage : qpc_pkg

// file: qpc_enc_model.sv
`timescale 1ns/1ps
module qpc_enc_model
  import qpc_pkg::*;
(
  // encoder lines
  output qpc_enc_t enc
);
  logic [1:0] ph = 2'd0;
  initial enc = '0;
  // forward rotation: a leads b, one channel per step
  function automatic logic [1:0] ab(input logic [1:0] p);
    return (p == 2'd0) ? 2'b00 : (p == 2'd1) ? 2'b10 : (p == 2'd2) ? 2'b11 : 2'b01;
  endfunction : ab
  // d of 2 flips both channels at once, an illegal move
  task automatic step(input int d);
    ph = ph + d[1:0];
    {enc.chanA, enc.chanB} = ab(ph);
  endtask : step
  task automatic idx(input logic lvl, input logic r);
    if (r) enc.idxDirect = lvl;
    else enc.idxDecoder = lvl;
  endtask : idx
endmodule : qpc_enc_model

// file: tb_quadrature_position_counter.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb_quadrature_position_counter;
  import qpc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  qpc_enc_t enc;
  qpc_cfg_t cfg = '{QPC_FREE, 1'b0, IDX_ROUTE_DECODER, 16'h0003};
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] latched;
  logic indexPulse;
  logic latchedValid;
  logic firstIndexSeen;
  int error_cnt = 0;
  int cmp_count = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  qpc_enc_model encoder (.enc(enc));
  qpc_quadrature_position_counter uut (.clk(clk), .reset_n(reset_n), .enc(enc), .cfg(cfg), .count(count),
    .indexPulse(indexPulse), .index_latched_count_out(latched), .latchedValid(latchedValid),
    .firstIndexSeen(firstIndexSeen));
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // settle past the three-cycle pipeline before looking
  task automatic mv(input int d);
    encoder.step(d);
    wt(5);
  endtask : mv
  task automatic pulse(input logic r, input logic expPulse);
    encoder.idx(1'b1, r);
    wt(2);
    encoder.idx(1'b0, r);
    // index output stands for one cycle only, three edges after the pin rose
    wt(1);
    `CHK(indexPulse, expPulse)
    wt(1);
    `CHK(indexPulse, 1'b0)
    wt(3);
  endtask : pulse
  task automatic t_wrap;
    mv(1);
    `CHK(count, 16'h0001)
    mv(1);
    mv(1);
    `CHK(count, 16'h0003)
    mv(1);
    `CHK(count, 16'h0000)
    mv(-1);
    `CHK(count, 16'h0003)
    mv(2);
    `CHK(count, 16'h0003)
  endtask : t_wrap
  task automatic t_modes;
    pulse(1'b0, 1'b0);
    `CHK(count, 16'h0003)
    `CHK(latched, 16'h0000)
    cfg.mode = QPC_FREE_CAPT;
    mv(-1);
    pulse(1'b0, 1'b1);
    `CHK(latched, 16'h0002)
    `CHK(count, 16'h0002)
    `CHK(latchedValid, 1'b1)
    cfg.mode = QPC_RST_EVERY;
    cfg.idxRoute = IDX_ROUTE_DIRECT;
    pulse(1'b1, 1'b1);
    `CHK(count, 16'h0000)
    `CHK(latched, 16'h0000)
    `CHK(latchedValid, 1'b0)
  endtask : t_modes
  task automatic t_first;
    cfg.mode = QPC_RST_FIRST;
    mv(1);
    `CHK(firstIndexSeen, 1'b0)
    pulse(1'b1, 1'b1);
    `CHK(count, 16'h0000)
    mv(1);
    pulse(1'b1, 1'b1);
    `CHK(count, 16'h0001)
    `CHK(firstIndexSeen, 1'b1)
  endtask : t_first
  // flipping polarity inverts both channels together, so no step from the flip itself
  task automatic t_pol;
    cfg.invertPolarity = 1'b1;
    wt(5);
    `CHK(count, 16'h0001)
    mv(1);
    `CHK(count, 16'h0002)
  endtask : t_pol
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    wt(16);
    reset_n = 1'b1;
    wt(4);
    t_wrap();
    t_modes();
    t_first();
    t_pol();
    final_report();
  end
endmodule : tb_quadrature_position_counter
